// ---- shared/ppsw_pkg.sv ----
package ppsw_pkg;
	// ------------------------------------------------------------
	// Register map (word offsets are byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL      = 8'h00; // enable, polarity, source, action
	localparam logic [7:0] OFS_START_DLY = 8'h04; // 0.1 s units
	localparam logic [7:0] OFS_WAKE_HYS  = 8'h08;
	localparam logic [7:0] OFS_WAKE_BIAS = 8'h0c;
	localparam logic [7:0] OFS_WAKE_THR  = 8'h10;
	localparam logic [7:0] OFS_WAKE_DLY  = 8'h14;
	localparam logic [7:0] OFS_WAKE_PCT  = 8'h18;
	localparam logic [7:0] OFS_SLP_PCT   = 8'h1c;
	localparam logic [7:0] OFS_UPPER     = 8'h20;
	localparam logic [7:0] OFS_LOWER     = 8'h24;
	localparam logic [7:0] OFS_SLP_DLY   = 8'h28;
	localparam logic [7:0] OFS_DEV_PCT   = 8'h2c;
	localparam logic [7:0] OFS_RANGE     = 8'h30;
	localparam logic [7:0] OFS_REF       = 8'h34;
	localparam logic [7:0] OFS_SLP_FREQ  = 8'h38;
	localparam logic [7:0] OFS_SLP_TOL   = 8'h3c;
	localparam logic [7:0] OFS_GAINS     = 8'h40;
	localparam logic [7:0] OFS_STATUS    = 8'h44;
	localparam logic [7:0] OFS_EFF_REF   = 8'h48;

	// ------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------
	localparam int CTRL_EN_LSB   = 0; // 2 bits
	localparam int CTRL_POL_BIT  = 2;
	localparam int CTRL_SRC_LSB  = 4; // 3 bits
	localparam int CTRL_ACT_BIT  = 8;

	// ------------------------------------------------------------
	// Reset values, limits and codes (percent x10, absolute x100, seconds x10, Hz x10)
	// ------------------------------------------------------------
	localparam logic [15:0] RST_WAKE_HYS = 16'h0002; // 0.2 Hz
	localparam logic [15:0] RST_SLP_DLY  = 16'h0001; // 0.1 s
	localparam logic [15:0] RST_UPPER    = 16'h03e8; // 100.0 %
	localparam logic [15:0] RST_RANGE    = 16'h0064; // 1.00
	localparam logic [15:0] MAX_PCT      = 16'h03e8; // 100.0 %
	localparam logic [15:0] MAX_TOL      = 16'h00fa; // 25.0 %
	localparam logic [15:0] MAX_RANGE    = 16'h270f; // 99.99
	localparam logic [15:0] MAX_START    = 16'h5dc0; // 2400.0 s
	localparam logic [15:0] MAX_DLY      = 16'h1770; // 600.0 s
	localparam logic [15:0] MIN_GAIN     = 16'h0001; // 0.01
	localparam logic [15:0] MAX_GAIN     = 16'h2710; // 100.00
	localparam logic [7:0]  MAX_DGAIN    = 8'hff;    // 2.55
	localparam logic [2:0]  SRC_KEYPAD   = 3'h7;
	localparam logic [1:0]  EN_MAX       = 2'h2;
	localparam logic [5:0]  FUNC_INVERT  = 6'h26;    // logic input function 38

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ       = 250_000_000;
	localparam int TICK_MS      = 100;
	localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;

	typedef enum logic [1:0] {PPSW_IDLE, PPSW_DELAY, PPSW_RUN, PPSW_SLEEP} ppsw_state_t;

	typedef struct packed {
		logic [15:0] feedback;   // absolute x100
		logic [15:0] op_freq;    // Hz x10
		logic [15:0] max_freq;   // Hz x10
	} ppsw_meas_t;

	typedef struct packed {
		logic        pid_active;
		logic        asleep;
		logic        stop_motor;
		logic        invert;
		logic        freq_mode;
		logic [15:0] freq_cmd;
		logic [15:0] eff_ref;
		logic [15:0] band_lo;
		logic [15:0] band_hi;
	} ppsw_out_t;
endpackage

// ---- logic/ppsw_ctrl.sv ----
`timescale 1ns/1ps
// Contract
// [R1] Source select steers frequency or PID reference
// [R2] Enable takes 0..2, feedback input one/two
// [R3] Source 7: keypad and parameter same reference
// [R4] Main and secondary sources combine to reference
// [R5] Gains accepted in documented ranges
// [R6] Nonzero start delay holds PID off
// [R7] During delay run frequency from source
// [R8] Polarity parameter sets error direction
// [R9] Input function 38 closed inverts error
// [R10] Deviation wake after bias for delay
// [R11] Threshold wake, absolute or percent, for delay
// [R12] Frequency wake above sleep plus hysteresis
// [R13] Wake mode priority deviation threshold frequency
// [R14] Sleep action stops or keeps running
// [R15] Threshold sleep above reference percent
// [R16] Frequency sleep: feedback and frequency together
// [R17] Threshold sleep outranks frequency sleep
// [R18] Zero sleep frequency disables sleep
// [R19] Reference clamped between lower and upper
// [R20] Limits are percent of sensor range
// [R21] Sensor range 0..99.99, default 1.00
// [R22] Control band is reference plus minus percent
// [R23] Delays timed in 0.1 s, restart
module ppsw_ctrl (
	input  wire logic               mclk,
	input  wire logic               reset,
	input  wire logic [7:0]         addr,
	input  wire logic [15:0]        wdata,
	input  wire logic               wr,
	input  wire logic               rd,
	output logic      [15:0]        rdata,
	input  wire logic               run_cmd,
	input  wire logic [5:0]         input_func,
	input  wire logic               input_pin,
	input  wire logic [15:0]        analog_input_one,
	input  wire logic [15:0]        analog_input_two,
	input  wire logic [15:0]        main_reference,
	input  wire logic [15:0]        secondary_reference,
	input  wire logic               combine_enable,
	input  wire ppsw_pkg::ppsw_meas_t meas,
	output ppsw_pkg::ppsw_out_t     status
);
	// ------------------------------------------------------------
	// Parameter registers
	// ------------------------------------------------------------
	logic [1:0]  pid_enable_select_q;
	logic        error_polarity_select_q;
	logic [2:0]  source_select_q;
	logic        sleep_action_select_q;
	logic [15:0] pid_start_delay_q, wake_hysteresis_band_q, wake_deviation_bias_q;
	logic [15:0] wake_feedback_threshold_q, wake_delay_time_q, wake_level_percent_q;
	logic [15:0] sleep_threshold_percent_q, reference_upper_limit_q, reference_lower_limit_q;
	logic [15:0] sleep_delay_time_q, allowed_deviation_percent_q, sensor_full_range_q;
	logic [15:0] keypad_pid_reference_q, sleep_frequency_q, sleep_tolerance_percent_q;
	logic [15:0] proportional_gain_q;
	logic [15:0] rdata_q;
	logic [15:0] feedback;
	ppsw_pkg::ppsw_state_t state_q;

	function automatic logic [15:0] sat(input logic [15:0] v, input logic [15:0] mx);
		sat = (v > mx) ? mx : v;
	endfunction

	always_ff @(posedge mclk) begin
		if (reset) begin
			pid_enable_select_q         <= 2'h0;
			error_polarity_select_q     <= 1'b0;
			source_select_q             <= 3'h0;
			sleep_action_select_q       <= 1'b0;
			pid_start_delay_q           <= 16'h0000;
			wake_hysteresis_band_q      <= ppsw_pkg::RST_WAKE_HYS;
			wake_deviation_bias_q       <= 16'h0000;
			wake_feedback_threshold_q   <= 16'h0000;
			wake_delay_time_q           <= 16'h0000;
			wake_level_percent_q        <= 16'h0000;
			sleep_threshold_percent_q   <= 16'h0000;
			reference_upper_limit_q     <= ppsw_pkg::RST_UPPER;
			reference_lower_limit_q     <= 16'h0000;
			sleep_delay_time_q          <= ppsw_pkg::RST_SLP_DLY;
			allowed_deviation_percent_q <= 16'h0000;
			sensor_full_range_q         <= ppsw_pkg::RST_RANGE;
			keypad_pid_reference_q      <= 16'h0000;
			sleep_frequency_q           <= 16'h0000;
			sleep_tolerance_percent_q   <= 16'h0000;
			proportional_gain_q         <= ppsw_pkg::MIN_GAIN;
		end else if (wr) begin
			unique case (addr)
				ppsw_pkg::OFS_CTRL: begin
					// Out-of-range enable codes saturate rather than alias
					pid_enable_select_q <= (wdata[ppsw_pkg::CTRL_EN_LSB +: 2] > ppsw_pkg::EN_MAX) ?
						ppsw_pkg::EN_MAX : wdata[ppsw_pkg::CTRL_EN_LSB +: 2]; // R2
					error_polarity_select_q <= wdata[ppsw_pkg::CTRL_POL_BIT];
					source_select_q         <= wdata[ppsw_pkg::CTRL_SRC_LSB +: 3];
					sleep_action_select_q   <= wdata[ppsw_pkg::CTRL_ACT_BIT];
				end
				ppsw_pkg::OFS_START_DLY: pid_start_delay_q <= sat(wdata, ppsw_pkg::MAX_START);
				ppsw_pkg::OFS_WAKE_HYS:  wake_hysteresis_band_q <= wdata;
				ppsw_pkg::OFS_WAKE_BIAS: wake_deviation_bias_q <= wdata;
				ppsw_pkg::OFS_WAKE_THR:  wake_feedback_threshold_q <= wdata;
				ppsw_pkg::OFS_WAKE_DLY:  wake_delay_time_q <= sat(wdata, ppsw_pkg::MAX_DLY); // R10
				ppsw_pkg::OFS_WAKE_PCT:  wake_level_percent_q <= sat(wdata, ppsw_pkg::MAX_PCT);
				ppsw_pkg::OFS_SLP_PCT:   sleep_threshold_percent_q <= sat(wdata, ppsw_pkg::MAX_PCT);
				ppsw_pkg::OFS_UPPER: begin
					reference_upper_limit_q <= sat(wdata, ppsw_pkg::MAX_PCT);
					if (reference_lower_limit_q > sat(wdata, ppsw_pkg::MAX_PCT))
						reference_lower_limit_q <= sat(wdata, ppsw_pkg::MAX_PCT); // R19
				end
				// Lower limit may never pass the upper
				ppsw_pkg::OFS_LOWER:     reference_lower_limit_q <= sat(wdata, reference_upper_limit_q); // R19
				ppsw_pkg::OFS_SLP_DLY:   sleep_delay_time_q <= sat(wdata, ppsw_pkg::MAX_DLY);
				ppsw_pkg::OFS_DEV_PCT:   allowed_deviation_percent_q <= sat(wdata, ppsw_pkg::MAX_PCT); // R22
				ppsw_pkg::OFS_RANGE:     sensor_full_range_q <= sat(wdata, ppsw_pkg::MAX_RANGE); // R21
				// Keypad and parameter writes land in one register
				ppsw_pkg::OFS_REF:       keypad_pid_reference_q <= sat(wdata, sensor_full_range_q); // R3 R21
				ppsw_pkg::OFS_SLP_FREQ:  sleep_frequency_q <= wdata;
				ppsw_pkg::OFS_SLP_TOL:   sleep_tolerance_percent_q <= sat(wdata, ppsw_pkg::MAX_TOL);
				ppsw_pkg::OFS_GAINS:     proportional_gain_q <= (wdata < ppsw_pkg::MIN_GAIN) ?
					ppsw_pkg::MIN_GAIN : sat(wdata, ppsw_pkg::MAX_GAIN); // R5
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pin synchroniser for the inversion terminal
	// ------------------------------------------------------------
	logic [2:0] pin_sync_q;
	logic       pin_level_q;
	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_sync_q  <= 3'h0;
			pin_level_q <= 1'b0;
		end else begin
			pin_sync_q <= {pin_sync_q[1:0], input_pin};
			if (pin_sync_q[1] == pin_sync_q[2])
				pin_level_q <= pin_sync_q[2];
		end
	end

	// ------------------------------------------------------------
	// Reference path
	// ------------------------------------------------------------
	logic [31:0] prod_upper, prod_lower, prod_dev, prod_slp, prod_tol, prod_wake, prod_freq;
	logic [15:0] raw_ref, upper_abs, lower_abs, eff_ref, dev_abs, slp_lvl, tol_lvl, wake_lvl;
	logic [16:0] comb_sum;
	logic        pid_on, invert;

	assign pid_on   = (pid_enable_select_q != 2'h0); // R1
	assign feedback = (pid_enable_select_q == ppsw_pkg::EN_MAX) ? analog_input_two
		: analog_input_one; // R2
	assign comb_sum = {1'b0, main_reference} + {1'b0, secondary_reference};
	always_comb begin
		if (combine_enable)
			raw_ref = comb_sum[16] ? 16'hffff : comb_sum[15:0]; // R4
		else if (source_select_q == ppsw_pkg::SRC_KEYPAD)
			raw_ref = keypad_pid_reference_q; // R3
		else
			raw_ref = main_reference;
	end
	assign prod_upper = 32'(sensor_full_range_q) * 32'(reference_upper_limit_q);
	assign prod_lower = 32'(sensor_full_range_q) * 32'(reference_lower_limit_q);
	assign upper_abs  = 16'(prod_upper / 32'd1000); // R20
	assign lower_abs  = 16'(prod_lower / 32'd1000); // R20
	always_comb begin
		if (pid_on && raw_ref > upper_abs)
			eff_ref = upper_abs; // R19
		else if (pid_on && raw_ref < lower_abs)
			eff_ref = lower_abs; // R19
		else
			eff_ref = raw_ref;
	end
	assign prod_dev  = 32'(eff_ref) * 32'(allowed_deviation_percent_q);
	assign dev_abs   = 16'(prod_dev / 32'd1000);
	assign prod_slp  = 32'(eff_ref) * 32'(sleep_threshold_percent_q);
	assign slp_lvl   = 16'(prod_slp / 32'd1000);
	assign prod_tol  = 32'(eff_ref) * 32'(sleep_tolerance_percent_q);
	assign tol_lvl   = 16'(prod_tol / 32'd1000);
	assign prod_wake = 32'(eff_ref) * 32'(wake_level_percent_q);
	assign wake_lvl  = 16'(prod_wake / 32'd1000);
	// Open loop speed scaled by reference over sensor range
	assign prod_freq = (sensor_full_range_q == 16'h0000) ? 32'h0
		: 32'(meas.max_freq) * 32'(eff_ref) / 32'(sensor_full_range_q); // R7
	assign invert = error_polarity_select_q ^
		(pin_level_q && input_func == ppsw_pkg::FUNC_INVERT); // R8 R9

	// ------------------------------------------------------------
	// Sleep and wake conditions
	// ------------------------------------------------------------
	logic        slp_thr, slp_frq, sleep_cond, wake_cond;
	logic [16:0] hys_sum;
	logic        dev_over;
	assign hys_sum  = {1'b0, sleep_frequency_q} + {1'b0, wake_hysteresis_band_q};
	assign dev_over = (eff_ref > feedback) && ((eff_ref - feedback) > wake_deviation_bias_q);
	assign slp_thr  = feedback > slp_lvl; // R15
	assign slp_frq  = (feedback >= tol_lvl) && (meas.op_freq <= sleep_frequency_q); // R16
	always_comb begin
		if (sleep_frequency_q == 16'h0000)
			sleep_cond = 1'b0; // R18
		else if (sleep_threshold_percent_q != 16'h0000)
			sleep_cond = slp_thr; // R17
		else
			sleep_cond = slp_frq; // R17
	end
	always_comb begin
		if (wake_deviation_bias_q != 16'h0000)
			wake_cond = dev_over; // R10 R13
		else if (wake_feedback_threshold_q != 16'h0000)
			wake_cond = feedback > wake_feedback_threshold_q; // R11 R13
		else if (wake_level_percent_q != 16'h0000)
			wake_cond = feedback > wake_lvl; // R11 R13
		else
			wake_cond = {1'b0, meas.op_freq} >= hys_sum; // R12 R13
	end

	// ------------------------------------------------------------
	// 0.1 s tick and qualification timers
	// ------------------------------------------------------------
	logic [24:0] tick_cnt_q;
	logic        tick;
	assign tick = (tick_cnt_q == 25'(ppsw_pkg::TICK_CYCLES - 1));
	always_ff @(posedge mclk) begin
		if (reset || tick)
			tick_cnt_q <= 25'h0;
		else
			tick_cnt_q <= tick_cnt_q + 25'h1;
	end

	logic [15:0] start_cnt_q, slp_cnt_q, wake_cnt_q;
	always_ff @(posedge mclk) begin
		if (reset || state_q != ppsw_pkg::PPSW_DELAY)
			start_cnt_q <= 16'h0000; // R23
		else if (tick && start_cnt_q != 16'hffff)
			start_cnt_q <= start_cnt_q + 16'h1;
	end
	always_ff @(posedge mclk) begin
		if (reset || !sleep_cond || state_q != ppsw_pkg::PPSW_RUN)
			slp_cnt_q <= 16'h0000; // R23
		else if (tick && slp_cnt_q != 16'hffff)
			slp_cnt_q <= slp_cnt_q + 16'h1;
	end
	always_ff @(posedge mclk) begin
		if (reset || !wake_cond || state_q != ppsw_pkg::PPSW_SLEEP)
			wake_cnt_q <= 16'h0000; // R23
		else if (tick && wake_cnt_q != 16'hffff)
			wake_cnt_q <= wake_cnt_q + 16'h1;
	end

	// ------------------------------------------------------------
	// Supervisory state machine
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_q <= ppsw_pkg::PPSW_IDLE;
		end else if (!run_cmd || !pid_on) begin
			state_q <= ppsw_pkg::PPSW_IDLE;
		end else begin
			unique case (state_q)
				ppsw_pkg::PPSW_IDLE:
					state_q <= (pid_start_delay_q != 16'h0000) ?
						ppsw_pkg::PPSW_DELAY : ppsw_pkg::PPSW_RUN; // R6
				ppsw_pkg::PPSW_DELAY:
					if (start_cnt_q >= pid_start_delay_q)
						state_q <= ppsw_pkg::PPSW_RUN; // R6
				ppsw_pkg::PPSW_RUN:
					if (sleep_cond && slp_cnt_q >= sleep_delay_time_q)
						state_q <= ppsw_pkg::PPSW_SLEEP; // R15 R16
				ppsw_pkg::PPSW_SLEEP:
					// Leaving sleep also if the function got disabled
					if ((wake_cond && wake_cnt_q >= wake_delay_time_q) ||
						sleep_frequency_q == 16'h0000)
						state_q <= ppsw_pkg::PPSW_RUN; // R10 R11 R12 R18
			endcase
		end
	end

	// ------------------------------------------------------------
	// Outputs, registered
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			status <= '0;
		end else begin
			status.pid_active <= (state_q == ppsw_pkg::PPSW_RUN); // R6
			status.asleep     <= (state_q == ppsw_pkg::PPSW_SLEEP);
			status.stop_motor <= (state_q == ppsw_pkg::PPSW_SLEEP) && !sleep_action_select_q; // R14
			status.invert     <= invert;
			status.freq_mode  <= !pid_on || state_q == ppsw_pkg::PPSW_DELAY; // R1 R7
			if (state_q == ppsw_pkg::PPSW_SLEEP && sleep_action_select_q)
				status.freq_cmd <= sleep_frequency_q; // R14
			else if (state_q == ppsw_pkg::PPSW_DELAY && source_select_q == ppsw_pkg::SRC_KEYPAD)
				status.freq_cmd <= 16'(prod_freq); // R7
			else
				status.freq_cmd <= main_reference;
			status.eff_ref <= eff_ref;
			status.band_lo <= (dev_abs > eff_ref) ? 16'h0000 : eff_ref - dev_abs; // R22
			status.band_hi <= 16'(({1'b0, eff_ref} + {1'b0, dev_abs} > 17'h0ffff) ?
				17'h0ffff : {1'b0, eff_ref} + {1'b0, dev_abs}); // R22
		end
	end

	always_ff @(posedge mclk) begin
		if (reset)
			rdata_q <= 16'h0000;
		else if (rd) begin
			unique case (addr)
				ppsw_pkg::OFS_CTRL: rdata_q <= {7'h0, sleep_action_select_q, 1'b0,
					source_select_q, 1'b0, error_polarity_select_q, pid_enable_select_q};
				ppsw_pkg::OFS_START_DLY: rdata_q <= pid_start_delay_q;
				ppsw_pkg::OFS_WAKE_HYS:  rdata_q <= wake_hysteresis_band_q;
				ppsw_pkg::OFS_WAKE_BIAS: rdata_q <= wake_deviation_bias_q;
				ppsw_pkg::OFS_WAKE_THR:  rdata_q <= wake_feedback_threshold_q;
				ppsw_pkg::OFS_WAKE_DLY:  rdata_q <= wake_delay_time_q;
				ppsw_pkg::OFS_WAKE_PCT:  rdata_q <= wake_level_percent_q;
				ppsw_pkg::OFS_SLP_PCT:   rdata_q <= sleep_threshold_percent_q;
				ppsw_pkg::OFS_UPPER:     rdata_q <= reference_upper_limit_q;
				ppsw_pkg::OFS_LOWER:     rdata_q <= reference_lower_limit_q;
				ppsw_pkg::OFS_SLP_DLY:   rdata_q <= sleep_delay_time_q;
				ppsw_pkg::OFS_DEV_PCT:   rdata_q <= allowed_deviation_percent_q;
				ppsw_pkg::OFS_RANGE:     rdata_q <= sensor_full_range_q;
				ppsw_pkg::OFS_REF:       rdata_q <= keypad_pid_reference_q;
				ppsw_pkg::OFS_SLP_FREQ:  rdata_q <= sleep_frequency_q;
				ppsw_pkg::OFS_SLP_TOL:   rdata_q <= sleep_tolerance_percent_q;
				ppsw_pkg::OFS_GAINS:     rdata_q <= proportional_gain_q;
				ppsw_pkg::OFS_STATUS:    rdata_q <= {12'h0, invert, 1'b0, 2'(state_q)};
				ppsw_pkg::OFS_EFF_REF:   rdata_q <= eff_ref;
				default:                 rdata_q <= 16'h0000;
			endcase
		end else
			rdata_q <= 16'h0000;
	end
	assign rdata = rdata_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_ref_clamp_hi: assert property (@(posedge mclk) disable iff (reset) // R19
		pid_on |-> eff_ref <= upper_abs) else $error("reference above upper limit");
	a_sleep_off: assert property (@(posedge mclk) disable iff (reset) // R18
		sleep_frequency_q == 16'h0000 |=> state_q != ppsw_pkg::PPSW_SLEEP)
		else $error("sleep while sleep function off");
	a_sleep_qual: assert property (@(posedge mclk) disable iff (reset) // R15
		state_q == ppsw_pkg::PPSW_RUN ##1 state_q == ppsw_pkg::PPSW_SLEEP
		|-> $past(slp_cnt_q) >= sleep_delay_time_q) else $error("sleep too early");
	a_wake_qual: assert property (@(posedge mclk) disable iff (reset) // R10
		$past(state_q) == ppsw_pkg::PPSW_SLEEP && state_q == ppsw_pkg::PPSW_RUN
		&& sleep_frequency_q != 16'h0000 |-> $past(wake_cond)) else $error("wake without cause");
	a_delay_hold: assert property (@(posedge mclk) disable iff (reset) // R6
		state_q == ppsw_pkg::PPSW_DELAY |=> !status.pid_active) else $error("PID active in delay");
	a_stop_action: assert property (@(posedge mclk) disable iff (reset) // R14
		state_q == ppsw_pkg::PPSW_SLEEP && !sleep_action_select_q |=> status.stop_motor)
		else $error("motor not stopped in sleep");
	a_pol_invert: assert property (@(posedge mclk) disable iff (reset) // R9
		pin_level_q && input_func == ppsw_pkg::FUNC_INVERT && !error_polarity_select_q
		|=> status.invert) else $error("polarity not inverted");
	a_counter_reset: assert property (@(posedge mclk) disable iff (reset) // R23
		!sleep_cond |=> slp_cnt_q == 16'h0000) else $error("sleep timer kept counting");
	c_sleep: cover property (@(posedge mclk) state_q == ppsw_pkg::PPSW_SLEEP);
	c_wake: cover property (@(posedge mclk)
		state_q == ppsw_pkg::PPSW_SLEEP ##1 state_q == ppsw_pkg::PPSW_RUN);
	c_delay: cover property (@(posedge mclk)
		state_q == ppsw_pkg::PPSW_DELAY ##1 state_q == ppsw_pkg::PPSW_RUN);
endmodule // ppsw_ctrl

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic                  mclk;
	logic                  reset;
	logic [7:0]            addr;
	logic [15:0]           wdata;
	logic                  wr;
	logic                  rd;
	logic [15:0]           rdata;
	logic                  run_cmd;
	logic [5:0]            input_func;
	logic                  input_pin;
	logic [15:0]           fb_one;
	logic [15:0]           fb_two;
	logic [15:0]           main_ref;
	logic [15:0]           sec_ref;
	logic                  comb;
	ppsw_pkg::ppsw_meas_t  meas;
	ppsw_pkg::ppsw_out_t   st;
	logic [15:0]           got;
	int                    fail_count;
	int                    total_checks;

	ppsw_ctrl uut (
		.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .run_cmd(run_cmd), .input_func(input_func),
		.input_pin(input_pin), .analog_input_one(fb_one), .analog_input_two(fb_two),
		.main_reference(main_ref), .secondary_reference(sec_ref),
		.combine_enable(comb), .meas(meas), .status(st)
	);

	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	// Each call owns one edge, so strobes never get two writes per step
	task automatic bus(input logic w, input logic r, input logic [7:0] a,
			input logic [15:0] d);
		@(posedge mclk);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, 8'h00, 16'h0000);
	endtask

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Data stands only in the cycle after the strobe
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] e);
		bus(1'b0, 1'b1, a, 16'h0000);
		bus(1'b0, 1'b0, 8'h00, 16'h0000);
		#1 chk(nm, e, rdata);
	endtask

	// Status is up to five registered stages behind its causes
	task automatic settle;
		repeat (8) @(posedge mclk);
		#1;
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Clock, reset, watchdog
	// ------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		end_sim();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		fail_count = 0;
		total_checks = 0;
		reset = 1'b1;
		{wr, rd, addr, wdata} = '0;
		run_cmd = 1'b0;
		input_func = 6'h00;
		input_pin = 1'b0;
		fb_one = 16'h0000;
		fb_two = 16'h0000;
		main_ref = 16'h0000;
		sec_ref = 16'h0000;
		comb = 1'b0;
		meas = '{feedback: 16'h0000, op_freq: 16'h0032, max_freq: 16'h01f4};
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		rd_chk("range", ppsw_pkg::OFS_RANGE, 16'h0064);
		rd_chk("upper", ppsw_pkg::OFS_UPPER, 16'h03e8);
		rd_chk("hys", ppsw_pkg::OFS_WAKE_HYS, 16'h0002);
		rd_chk("sdly", ppsw_pkg::OFS_SLP_DLY, 16'h0001);
		rd_chk("wdly", ppsw_pkg::OFS_WAKE_DLY, 16'h0000);
		rd_chk("unmapped", 8'h50, 16'h0000);
		wr_reg(ppsw_pkg::OFS_RANGE, 16'hffff);
		rd_chk("range_sat", ppsw_pkg::OFS_RANGE, 16'h270f);
		wr_reg(ppsw_pkg::OFS_RANGE, 16'h0064);
		$display("test defaults done");
		// Limits 10..50 % of range 1.00
		wr_reg(ppsw_pkg::OFS_UPPER, 16'h01f4);
		wr_reg(ppsw_pkg::OFS_LOWER, 16'h0064);
		wr_reg(ppsw_pkg::OFS_REF, 16'h0050);
		wr_reg(ppsw_pkg::OFS_CTRL, 16'h0071);
		run_cmd <= 1'b1;
		settle();
		rd_chk("ref_hi", ppsw_pkg::OFS_EFF_REF, 16'h0032);
		chk("pid_active", 16'h0001, {15'h0, st.pid_active});
		wr_reg(ppsw_pkg::OFS_REF, 16'h0005);
		settle();
		rd_chk("ref_lo", ppsw_pkg::OFS_EFF_REF, 16'h000a);
		wr_reg(ppsw_pkg::OFS_REF, 16'h0028);
		wr_reg(ppsw_pkg::OFS_DEV_PCT, 16'h01f4);
		settle();
		chk("eff_ref", 16'h0028, st.eff_ref);
		chk("band_lo", 16'h0014, st.band_lo);
		chk("band_hi", 16'h003c, st.band_hi);
		$display("test reference done");
		chk("inv_off", 16'h0000, {15'h0, st.invert});
		wr_reg(ppsw_pkg::OFS_CTRL, 16'h0075);
		settle();
		chk("inv_par", 16'h0001, {15'h0, st.invert});
		input_func <= ppsw_pkg::FUNC_INVERT;
		input_pin <= 1'b1;
		settle();
		chk("inv_both", 16'h0000, {15'h0, st.invert});
		wr_reg(ppsw_pkg::OFS_CTRL, 16'h0071);
		settle();
		chk("inv_pin", 16'h0001, {15'h0, st.invert});
		input_pin <= 1'b0;
		$display("test polarity done");
		// Zero delays so sleep and wake qualify at once
		wr_reg(ppsw_pkg::OFS_SLP_DLY, 16'h0000);
		wr_reg(ppsw_pkg::OFS_SLP_PCT, 16'h01f4);
		wr_reg(ppsw_pkg::OFS_WAKE_BIAS, 16'h000a);
		fb_one <= 16'h001e;
		settle();
		chk("no_sleep", 16'h0000, {15'h0, st.asleep});
		wr_reg(ppsw_pkg::OFS_SLP_FREQ, 16'h0064);
		settle();
		chk("asleep", 16'h0001, {15'h0, st.asleep});
		chk("stop", 16'h0001, {15'h0, st.stop_motor});
		rd_chk("state_slp", ppsw_pkg::OFS_STATUS, 16'h0003);
		fb_one <= 16'h0005;
		settle();
		chk("woken", 16'h0000, {15'h0, st.asleep});
		rd_chk("state_run", ppsw_pkg::OFS_STATUS, 16'h0002);
		wr_reg(ppsw_pkg::OFS_CTRL, 16'h0171);
		fb_one <= 16'h001e;
		settle();
		chk("asleep2", 16'h0001, {15'h0, st.asleep});
		chk("keep_run", 16'h0000, {15'h0, st.stop_motor});
		chk("slp_speed", 16'h0064, st.freq_cmd);
		chk("pid_mode", 16'h0000, {15'h0, st.freq_mode});
		$display("test sleep done");
		// Deviation off, frequency wake not met: stays asleep
		wr_reg(ppsw_pkg::OFS_WAKE_BIAS, 16'h0000);
		wr_reg(ppsw_pkg::OFS_SLP_PCT, 16'h03e8);
		settle();
		chk("rank", 16'h0001, {15'h0, st.asleep});
		wr_reg(ppsw_pkg::OFS_WAKE_THR, 16'h0014);
		settle();
		chk("thr_wake", 16'h0000, {15'h0, st.asleep});
		wr_reg(ppsw_pkg::OFS_WAKE_THR, 16'h0000);
		wr_reg(ppsw_pkg::OFS_SLP_TOL, 16'h00fa);
		wr_reg(ppsw_pkg::OFS_SLP_PCT, 16'h0000);
		settle();
		chk("frq_sleep", 16'h0001, {15'h0, st.asleep});
		meas.op_freq <= 16'h0070;
		settle();
		chk("frq_wake", 16'h0000, {15'h0, st.asleep});
		$display("test wake modes done");
		wr_reg(ppsw_pkg::OFS_START_DLY, 16'h0001);
		run_cmd <= 1'b0;
		settle();
		run_cmd <= 1'b1;
		settle();
		rd_chk("state_dly", ppsw_pkg::OFS_STATUS, 16'h0001);
		chk("dly_off", 16'h0000, {15'h0, st.pid_active});
		chk("dly_mode", 16'h0001, {15'h0, st.freq_mode});
		chk("dly_freq", 16'h00c8, st.freq_cmd);
		wr_reg(ppsw_pkg::OFS_START_DLY, 16'h0000);
		settle();
		chk("dly_end", 16'h0001, {15'h0, st.pid_active});
		$display("test start delay done");
		wr_reg(ppsw_pkg::OFS_CTRL, 16'h0002);
		main_ref <= 16'h0010;
		sec_ref <= 16'h0008;
		comb <= 1'b1;
		meas.op_freq <= 16'h0032;
		settle();
		chk("comb_ref", 16'h0018, st.eff_ref);
		chk("fb_two_lo", 16'h0000, {15'h0, st.asleep});
		fb_two <= 16'h0014;
		settle();
		chk("fb_two_hi", 16'h0001, {15'h0, st.asleep});
		wr_reg(ppsw_pkg::OFS_CTRL, 16'h0000);
		settle();
		chk("off_mode", 16'h0001, {15'h0, st.freq_mode});
		chk("off_freq", 16'h0010, st.freq_cmd);
		wr_reg(ppsw_pkg::OFS_UPPER, 16'h0032);
		rd_chk("lower_cap", ppsw_pkg::OFS_LOWER, 16'h0032);
		$display("test sources done");
		end_sim();
	end
endmodule // testbench
